//--- fq_consts.svh
// Constants of the flash query host: command codes, register offsets and timing counts.
// Assumes inclusion by the package, the host modules and the testbench only.
//
// Overview of operation
// - Identifier mode persists across reads until another valid command other than status clear is written.
// - Block status is valid only while the ready flag reads one.
// - Status latched on strobe fall; strobe must rise before the next read.
// - Multi-word write command yields extended status; reissue it to refresh.
// - The host clears failure flags with a single status-clear write cycle, taken only while the write machine is idle.
`ifndef FQ_CONSTS_SVH
`define FQ_CONSTS_SVH

// ****************************************
// Flash command codes
// ****************************************
`define FQ_CMD_READ_ARRAY 8'hff
`define FQ_CMD_READ_ID 8'h90
`define FQ_CMD_QUERY 8'h98
`define FQ_CMD_READ_STATUS 8'h70
`define FQ_CMD_CLEAR_STATUS 8'h50
`define FQ_CMD_MULTI_WRITE 8'he8

// ****************************************
// Flash identifier map (word addresses) and status bit positions
// ****************************************
`define FQ_ID_MAKER_ADDR 21'h000000
`define FQ_ID_PART_ADDR 21'h000002
`define FQ_ID_BLOCK_OFFS 16'h0004
`define FQ_BS_LOCK_BIT 0
`define FQ_BS_ERASE_BIT 1
`define FQ_SR_READY_BIT 7
`define FQ_SR_ERASE_FAIL_BIT 5
`define FQ_SR_WRITE_FAIL_BIT 4
`define FQ_SR_SUPPLY_LOW_BIT 3
`define FQ_SR_LOCKED_FAIL_BIT 1

// ****************************************
// APB register offsets of the host
// ****************************************
`define FQ_REG_CTRL 12'h000
`define FQ_REG_ADDR 12'h004
`define FQ_REG_STAT 12'h008
`define FQ_REG_DATA 12'h00c
`define FQ_REG_IRQ_STAT 12'h010
`define FQ_REG_IRQ_MASK 12'h014
`define FQ_CTRL_RESET 32'h0000_0000

// Control word fields: [7:0] command, [10:8] operation, [11] byte mode.
`define FQ_CTRL_OP_LSB 8
`define FQ_CTRL_BYTE_BIT 11

// ****************************************
// Timing
// ****************************************
`define FQ_CLK_NS 50
`define FQ_STROBE_NS 100
`define FQ_RECOVER_NS 50
`define FQ_STROBE_CYC ((`FQ_STROBE_NS + `FQ_CLK_NS - 1) / `FQ_CLK_NS)
`define FQ_RECOVER_CYC ((`FQ_RECOVER_NS + `FQ_CLK_NS - 1) / `FQ_CLK_NS)

`endif

//--- fq_flash_model.sv
// Behavioural model of the parallel flash that the query host drives.
// Assumes the host makes every strobe; no clock reaches the model.
`timescale 1ns/1ps
`default_nettype none

module fq_flash_model #(
    parameter int ADDR_W = 21,
    parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value.
    parameter logic [7:0] PART_CODE = 8'h5a // Arbitrary value.
) (
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_dq_oe,
    output logic [15:0] flash_dq_in,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_byte_n,
    input wire logic powerdown_reset_n,
    output logic proto_err
);
    // ****************************************
    // Internal state, set by the bench where it plays the write machine
    // ****************************************
    logic [7:0] mode_r = 8'hff;
    logic [6:0] sr_flags = 7'h00;
    logic wsm_busy = 1'b0;
    logic [7:0] xsr_live = 8'h80;
    logic [7:0] xsr_lat = 8'h80;
    logic [7:0] sr_lat = 8'h80;
    logic [31:0] blk_lock = 32'h0000_0000;
    logic [31:0] blk_efail = 32'h0000_0000;
    logic [7:0] wdat = 8'h00;
    logic [15:0] last_q = 16'h0000;
    logic [15:0] rd_q;
    logic [7:0] q_byte;
    logic [5:0] q_offs;
    logic [4:0] blk;
    wire wr_act = powerdown_reset_n && !flash_ce_n && !flash_we_n;
    wire rd_act = powerdown_reset_n && !flash_ce_n && !flash_oe_n;

    initial proto_err = 1'b0;

    // Command byte is taken 10 ns into the strobe, so edge races with the host cannot matter.
    always @(posedge wr_act) begin
        #10;
        wdat = flash_dq_out[7:0];
        if (flash_dq_out[15:8] !== 8'h00 || flash_dq_oe !== 1'b1 || !flash_oe_n) begin
            proto_err = 1'b1;
        end
    end

    // Recognised commands other than 8'h50 switch the read mode when the write strobe ends.
    always @(negedge wr_act) begin
        case (wdat)
            8'h90, 8'h98, 8'h70, 8'hff: mode_r = wdat;
            8'he8: begin
                mode_r = wdat;
                xsr_lat = xsr_live;
            end
            8'h50: if (!wsm_busy) sr_flags = sr_flags & ~7'h3a;
            default: ;
        endcase
    end

    // Status is latched as the read strobe opens; both strobes low is a host fault.
    always @(posedge rd_act) begin
        sr_lat = {!wsm_busy, sr_flags};
        if (!flash_we_n) proto_err = 1'b1;
    end

    // Read data chosen by the current mode.
    always @* begin
        q_offs = flash_byte_n ? flash_addr[5:0] : flash_addr[6:1];
        blk = flash_addr[20:16];
        case (q_offs)
            6'h10: q_byte = 8'h51;
            6'h11: q_byte = 8'h52;
            6'h12: q_byte = 8'h59;
            default: q_byte = 8'h00;
        endcase
        case (mode_r)
            8'h90: begin
                case (flash_addr[15:0])
                    16'h0000, 16'h0001: rd_q = {8'h00, MAKER_CODE};
                    16'h0002, 16'h0003: rd_q = {8'h00, PART_CODE};
                    16'h0004, 16'h0005: rd_q = wsm_busy ? ~last_q :
                        {14'h0000, blk_efail[blk], blk_lock[blk]};
                    default: rd_q = 16'h0000;
                endcase
            end
            8'h70: rd_q = {8'h00, sr_lat};
            8'he8: rd_q = {8'h00, xsr_lat};
            8'h98: rd_q = {flash_byte_n ? 8'h00 : ~q_byte, q_byte};
            default: rd_q = ~flash_addr[15:0];
        endcase
    end

    // A released bus shows the inverse of the last value, never a held copy.
    assign flash_dq_in = rd_act ? rd_q : ~last_q;
    always @(negedge rd_act) last_q = rd_q;
endmodule

`default_nettype wire

//--- fq_host.sv
// Host controller that issues command writes and read cycles to a parallel flash.
// Assumes an APB master on the register side and the flash pins on the other.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fq_consts.svh"

module fq_host
    import fq_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int BLOCK_SHIFT = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_byte_n,
    output logic powerdown_reset_n
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_addr_check
        $error("fq_host address width unsupported");
    end
    if (BLOCK_SHIFT >= ADDR_W || BLOCK_SHIFT < 4) begin : g_shift_check
        $error("fq_host block shift bad");
    end

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] ctrl_r;
    logic [31:0] addr_r;
    logic [15:0] data_r;
    logic [7:0] mode_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic busy_r;
    logic ready_seen_r;
    logic start_r;
    logic done_pulse;
    logic err_pulse;
    fq_state_t state_r;
    fq_op_t op_r;
    logic timer_load;
    logic [3:0] timer_count;
    logic timer_expired;

    wire logic wr_en = psel && penable && pwrite;
    wire logic rd_en = psel && !penable && !pwrite;
    wire logic is_read_op = (op_r != FQ_OP_WRITE_CMD);

    // Recognised command codes; only these move the tracked read mode.
    function automatic logic known_cmd(input logic [7:0] c);
        known_cmd = (c == `FQ_CMD_READ_ARRAY) || (c == `FQ_CMD_READ_ID) ||
                    (c == `FQ_CMD_QUERY) || (c == `FQ_CMD_READ_STATUS) ||
                    (c == `FQ_CMD_CLEAR_STATUS) || (c == `FQ_CMD_MULTI_WRITE);
    endfunction

    // Address of a block's status byte: block select kept, offset replaced.
    function automatic logic [ADDR_W-1:0] block_stat_addr(input logic [31:0] a);
        logic [ADDR_W-1:0] hi;
        hi = a[ADDR_W-1:0] >> BLOCK_SHIFT;
        block_stat_addr = (hi << BLOCK_SHIFT) | ADDR_W'(`FQ_ID_BLOCK_OFFS);
    endfunction

    // ****************************************
    // APB slave
    // ****************************************
    // Zero-wait slave; writes to the control register start a flash cycle unless busy_r is set or the operation is FQ_OP_NONE.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `FQ_CTRL_RESET;
            addr_r <= 32'h0000_0000;
            irq_mask_r <= 3'h0;
            start_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            if (wr_en) begin
                unique case (paddr)
                    `FQ_REG_CTRL: begin
                        ctrl_r <= pwdata;
                        start_r <= !busy_r;
                    end
                    `FQ_REG_ADDR: addr_r <= pwdata;
                    `FQ_REG_IRQ_MASK: irq_mask_r <= pwdata[2:0];
                    default: ;
                endcase
            end
        end
    end

    // Read mux and one-cycle answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (rd_en) begin
                unique case (paddr)
                    `FQ_REG_CTRL: prdata <= ctrl_r;
                    `FQ_REG_ADDR: prdata <= addr_r;
                    `FQ_REG_STAT: prdata <= {23'h0, mode_r, busy_r};
                    `FQ_REG_DATA: prdata <= {16'h0, data_r};
                    `FQ_REG_IRQ_STAT: prdata <= {29'h0, irq_stat_r};
                    `FQ_REG_IRQ_MASK: prdata <= {29'h0, irq_mask_r};
                    default: prdata <= 32'h0000_0000;
                endcase
                pslverr <= (paddr > `FQ_REG_IRQ_MASK) || (paddr[1:0] != 2'b00);
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    // Bit0 done, bit1 flash failure flag seen, bit2 block erase invalid.
    // The read clear acts in the cycle that captures the read data, so no set slips by.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 3'h0;
            irq <= 1'b0;
        end else begin
            logic [2:0] set_v;
            set_v = {err_pulse && op_r == FQ_OP_BLOCK_STAT, err_pulse && op_r == FQ_OP_STATUS,
                     done_pulse};
            if (rd_en && paddr == `FQ_REG_IRQ_STAT) begin
                irq_stat_r <= set_v;
            end else begin
                irq_stat_r <= irq_stat_r | set_v;
            end
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ****************************************
    // Flash bus cycle sequencer
    // ****************************************
    fq_timer #(
        .WIDTH(4)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(timer_load),
        .count(timer_count),
        .expired(timer_expired)
    );

    // Setup, strobe low for the access time, strobe high for recovery.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= FQ_IDLE;
            op_r <= FQ_OP_NONE;
            busy_r <= 1'b0;
            timer_load <= 1'b0;
            timer_count <= 4'h0;
            done_pulse <= 1'b0;
        end else begin
            timer_load <= 1'b0;
            done_pulse <= 1'b0;
            unique case (state_r)
                FQ_IDLE: begin
                    if (start_r && ctrl_r[10:8] != FQ_OP_NONE) begin
                        op_r <= fq_op_t'(ctrl_r[10:8]);
                        busy_r <= 1'b1;
                        state_r <= FQ_SETUP;
                    end
                end
                FQ_SETUP: begin
                    timer_load <= 1'b1;
                    timer_count <= 4'(`FQ_STROBE_CYC);
                    state_r <= FQ_STROBE;
                end
                FQ_STROBE: begin
                    if (timer_expired) begin
                        timer_load <= 1'b1;
                        timer_count <= 4'(`FQ_RECOVER_CYC);
                        state_r <= FQ_RECOVER;
                    end
                end
                FQ_RECOVER: begin
                    // Strobe back high before any further read so status is fresh.
                    if (timer_expired) state_r <= FQ_DONE;
                end
                FQ_DONE: begin
                    busy_r <= 1'b0;
                    done_pulse <= 1'b1;
                    state_r <= FQ_IDLE;
                end
                default: state_r <= FQ_IDLE;
            endcase
        end
    end

    // Flash pins follow the sequencer state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_addr <= '0;
            flash_dq_out <= 16'h0000;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_byte_n <= 1'b1;
            powerdown_reset_n <= 1'b0;
        end else begin
            powerdown_reset_n <= 1'b1;
            flash_byte_n <= !ctrl_r[`FQ_CTRL_BYTE_BIT];
            if (state_r == FQ_SETUP) begin
                // Block status reads keep the block select and force offset 4.
                flash_addr <= (op_r == FQ_OP_BLOCK_STAT) ?
                    block_stat_addr(addr_r) : addr_r[ADDR_W-1:0];
                flash_dq_out <= {8'h00, ctrl_r[7:0]};
                flash_dq_oe <= !is_read_op;
                flash_ce_n <= 1'b0;
                flash_we_n <= is_read_op;
                flash_oe_n <= !is_read_op;
            end else if (state_r == FQ_RECOVER || state_r == FQ_IDLE) begin
                flash_ce_n <= 1'b1;
                flash_oe_n <= 1'b1;
                flash_we_n <= 1'b1;
                flash_dq_oe <= 1'b0;
            end
        end
    end

    // Read data capture at the end of the strobe, with failure checks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= 16'h0000;
            err_pulse <= 1'b0;
        end else begin
            err_pulse <= 1'b0;
            if (state_r == FQ_STROBE && timer_expired && is_read_op) begin
                data_r <= flash_dq_in;
                if (op_r == FQ_OP_STATUS) begin
                    // Sticky failure flags accumulate until cleared.
                    err_pulse <= flash_dq_in[`FQ_SR_ERASE_FAIL_BIT] ||
                                 flash_dq_in[`FQ_SR_WRITE_FAIL_BIT] ||
                                 flash_dq_in[`FQ_SR_SUPPLY_LOW_BIT] ||
                                 flash_dq_in[`FQ_SR_LOCKED_FAIL_BIT];
                end else if (op_r == FQ_OP_BLOCK_STAT) begin
                    err_pulse <= flash_dq_in[`FQ_BS_ERASE_BIT] && ready_seen_r;
                end
            end
        end
    end

    // Ready flag of the last status read, set from reset; block status is trusted unless that read was busy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_seen_r <= 1'b1;
        end else if (state_r == FQ_STROBE && timer_expired && op_r == FQ_OP_STATUS) begin
            ready_seen_r <= flash_dq_in[`FQ_SR_READY_BIT];
        end
    end

    // Tracked read mode of the flash; a plain read never changes it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= `FQ_CMD_READ_ARRAY;
        end else if (state_r == FQ_DONE && op_r == FQ_OP_WRITE_CMD &&
                     known_cmd(ctrl_r[7:0]) && ctrl_r[7:0] != `FQ_CMD_CLEAR_STATUS) begin
            mode_r <= ctrl_r[7:0];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_strobe_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
        !(!flash_oe_n && !flash_we_n)) else $error("oe and we low together");

    a_write_drives_dq: assert property (@(posedge pclk) disable iff (!presetn)
        !flash_we_n |-> flash_dq_oe && !flash_ce_n) else $error("write without drive");

    a_read_releases_dq: assert property (@(posedge pclk) disable iff (!presetn)
        !flash_oe_n |-> !flash_dq_oe) else $error("bus contention on read");

    a_strobe_rises_between: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flash_oe_n) |-> flash_oe_n[*2]) else $error("strobe recovery short");

    a_reset_released: assert property (@(posedge pclk) disable iff (!presetn)
        busy_r |-> powerdown_reset_n) else $error("cycle under power-down");

    a_mode_holds_read: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == FQ_DONE && op_r != FQ_OP_WRITE_CMD) |=> $stable(mode_r))
        else $error("read changed mode");

    a_block_offset: assert property (@(posedge pclk) disable iff (!presetn)
        (!flash_oe_n && op_r == FQ_OP_BLOCK_STAT) |->
        flash_addr[BLOCK_SHIFT-1:0] == BLOCK_SHIFT'(`FQ_ID_BLOCK_OFFS))
        else $error("block status offset wrong");

    a_cycle_bounded: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(busy_r) |-> ##[3:12] !busy_r) else $error("flash cycle too long");

endmodule

`default_nettype wire

//--- fq_pkg.sv
// Types of the flash query host.
// Assumes the constants header sits in the same folder.
`include "fq_consts.svh"

package fq_pkg;

    // Operation requested through the control register.
    typedef enum logic [2:0] {
        FQ_OP_NONE = 3'b000,
        FQ_OP_WRITE_CMD = 3'b001,
        FQ_OP_READ = 3'b010,
        FQ_OP_BLOCK_STAT = 3'b011,
        FQ_OP_STATUS = 3'b100
    } fq_op_t;

    // Bus cycle sequencer states.
    typedef enum logic [2:0] {
        FQ_IDLE = 3'b000,
        FQ_SETUP = 3'b001,
        FQ_STROBE = 3'b010,
        FQ_RECOVER = 3'b011,
        FQ_DONE = 3'b100
    } fq_state_t;

endpackage

//--- fq_timer.sv
// Down counter that times strobe and recovery phases of a flash bus cycle.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module fq_timer #(
    parameter int WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic expired
);

    // ****************************************
    // Counter
    // ****************************************
    logic [WIDTH-1:0] cnt_r;

    if (WIDTH < 2) begin : g_width_check
        $error("fq_timer width too small");
    end

    // Loads the count, then counts down to zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Expiry is high once the loaded time has run out.
    assign expired = (cnt_r == '0) && !load;

endmodule

`default_nettype wire

//--- tb_fq_host.sv
// Self-checking bench of the query host against the flash model.
// Assumes the host and model sources compile ahead of this file.
`timescale 1ns/1ps
`default_nettype none
`include "fq_consts.svh"

module tb_fq_host import fq_pkg::*;;
    localparam logic [7:0] MK = 8'h3c;
    localparam logic [7:0] PT = 8'h5a;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, proto_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [20:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in;
    logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_byte_n, powerdown_reset_n;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    int i;
    logic serr;
    logic [6:0] qa [8] = '{7'h10, 7'h11, 7'h12, 7'h1b, 7'h20, 7'h21, 7'h23, 7'h24};
    logic [7:0] qd [8] = '{8'h51, 8'h52, 8'h59, 8'h00, 8'h51, 8'h51, 8'h52, 8'h59};
    logic qb [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

    always #25 pclk = ~pclk;

    fq_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_byte_n(flash_byte_n),
        .powerdown_reset_n(powerdown_reset_n));

    fq_flash_model #(.ADDR_W(21), .MAKER_CODE(MK), .PART_CODE(PT)) i_flash (
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .flash_byte_n(flash_byte_n),
        .powerdown_reset_n(powerdown_reset_n), .proto_err(proto_err));

    // ****************************************
    // Shared tasks
    // ****************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compares one seen value with its expectation.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rdat, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] t;
        logic e;
        apb(1'b1, a, d, t, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0000_0000, d, e);
    endtask

    // Starts one flash operation, waits for busy to drop and fetches DATA.
    task automatic op(input logic [7:0] cmd, input fq_op_t opc, input logic bm,
        input logic [20:0] a, output logic [31:0] d);
        logic [31:0] s;
        wr(`FQ_REG_ADDR, {11'h000, a});
        wr(`FQ_REG_CTRL, {20'h00000, bm, opc, cmd});
        do begin
            rd(`FQ_REG_STAT, s);
        end while (s[0] !== 1'b0);
        rd(`FQ_REG_DATA, d);
    endtask

    // Cuts a hung run short.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("mismatch at %0t: run did not finish", $time);
            conclude();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`FQ_REG_STAT, r);
        check(r, 32'h0000_01fe);
        rd(`FQ_REG_CTRL, r);
        check(r, `FQ_CTRL_RESET);
        check({31'h0, powerdown_reset_n}, 32'h1);
        apb(1'b0, 12'h020, 32'h0, r, serr);
        check({r[30:0], serr}, 32'h1);
        // Identifier codes, repeated reads and an unrecognised command.
        op(`FQ_CMD_READ_ID, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        rd(`FQ_REG_STAT, r);
        check(r, 32'h0000_0120);
        for (i = 0; i < 4; i++) begin
            op(8'h00, FQ_OP_READ, 1'b0, 21'(i), r);
            check(r, {24'h0, (i < 2) ? MK : PT});
        end
        op(8'h00, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        op(8'h00, FQ_OP_READ, 1'b0, 21'h1, r);
        check(r, {24'h0, MK});
        // Block status codes with lock and failed erase.
        i_flash.blk_lock[3] = 1'b1;
        i_flash.blk_efail[3] = 1'b1;
        i_flash.blk_lock[5] = 1'b1;
        rd(`FQ_REG_IRQ_STAT, r);
        op(8'h00, FQ_OP_BLOCK_STAT, 1'b0, 21'h03_1234, r);
        check(r, 32'h3);
        rd(`FQ_REG_IRQ_STAT, r);
        check(r & 32'h4, 32'h4);
        op(8'h00, FQ_OP_READ, 1'b0, 21'h05_0004, r);
        check(r, 32'h1);
        op(8'h00, FQ_OP_BLOCK_STAT, 1'b0, 21'h00_0000, r);
        check(r, 32'h0);
        // A busy status read makes a following block status untrusted.
        i_flash.wsm_busy = 1'b1;
        op(`FQ_CMD_READ_STATUS, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        op(8'h00, FQ_OP_STATUS, 1'b0, 21'h0, r);
        op(`FQ_CMD_READ_ID, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        rd(`FQ_REG_IRQ_STAT, r);
        op(8'h00, FQ_OP_BLOCK_STAT, 1'b0, 21'h03_0000, r);
        rd(`FQ_REG_IRQ_STAT, r);
        check(r & 32'h4, 32'h0);
        i_flash.wsm_busy = 1'b0;
        // Status reads, fresh latching and the sticky clear.
        i_flash.sr_flags = 7'h22;
        op(`FQ_CMD_READ_STATUS, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        op(8'h00, FQ_OP_STATUS, 1'b0, 21'h0, r);
        check(r, 32'ha2);
        rd(`FQ_REG_IRQ_STAT, r);
        check(r & 32'h2, 32'h2);
        i_flash.sr_flags = 7'h32;
        op(8'h00, FQ_OP_READ, 1'b0, 21'h1f_0000, r);
        check(r, 32'hb2);
        i_flash.wsm_busy = 1'b1;
        op(`FQ_CMD_CLEAR_STATUS, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        op(8'h00, FQ_OP_READ, 1'b0, 21'h0, r);
        check(r, 32'h32);
        i_flash.wsm_busy = 1'b0;
        op(`FQ_CMD_CLEAR_STATUS, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        op(8'h00, FQ_OP_READ, 1'b0, 21'h0, r);
        check(r, 32'h80);
        rd(`FQ_REG_STAT, r);
        check(r, 32'h0000_00e0);
        // Extended status is refreshed only by reissuing its command.
        op(`FQ_CMD_MULTI_WRITE, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        i_flash.xsr_live = 8'h00;
        op(8'h00, FQ_OP_READ, 1'b0, 21'h0, r);
        check(r, 32'h80);
        op(`FQ_CMD_MULTI_WRITE, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        op(8'h00, FQ_OP_READ, 1'b0, 21'h0, r);
        check(r, 32'h00);
        // Query entries in word and byte modes.
        op(`FQ_CMD_QUERY, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        for (i = 0; i < 8; i++) begin
            op(8'h00, FQ_OP_READ, qb[i], {14'h0000, qa[i]}, r);
            check(qb[i] ? (r & 32'hff) : r, {24'h0, qd[i]});
        end
        // Done interrupt masked and unmasked, back in array mode.
        rd(`FQ_REG_IRQ_STAT, r);
        wr(`FQ_REG_IRQ_MASK, 32'h1);
        op(`FQ_CMD_READ_ARRAY, FQ_OP_WRITE_CMD, 1'b0, 21'h0, r);
        check({31'h0, irq}, 32'h1);
        rd(`FQ_REG_IRQ_STAT, r);
        check(r & 32'h1, 32'h1);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rd(`FQ_REG_IRQ_STAT, r);
        check(r, 32'h0);
        wr(`FQ_REG_IRQ_MASK, 32'h0);
        op(8'h00, FQ_OP_READ, 1'b0, 21'h00_1234, r);
        check(r, 32'h0000_edcb);
        check({31'h0, irq}, 32'h0);
        check({31'h0, proto_err}, 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
